// ===== goc_host.sv
// Purpose: Host model making PWM and the quick reset
// Assumes: Bench holds levels when run_i is low
// Notes:   Half-bridge legs complementary while running
`timescale 1ns/10ps
module goc_host (
  input  wire logic       sys_clk_i,
  input  wire logic       run_i,
  input  wire logic [5:0] hold_i,
  input  wire logic       quick_req_i,
  output logic      [5:0] pwm_o,
  output logic            quick_rst_o
);
  logic [3:0] ph_r = 4'h0;
  always_ff @(posedge sys_clk_i) ph_r <= ph_r + 4'h1;
  assign pwm_o       = run_i ? {3{ph_r[3], ~ph_r[3]}} : hold_i;
  // One clock, far below the quick reset ceiling
  assign quick_rst_o = quick_req_i;
endmodule // goc_host

// ===== goc_map.svh
// Purpose: Named constants for the gate overcurrent protection block
// Assumes: 100 MHz system clock
// Notes:   Mode codes are a local choice
`ifndef GOC_MAP_SVH
`define GOC_MAP_SVH
`define GOC_CLK_MHZ        100
`define GOC_TIMER_US       64
`define GOC_TIMER_CYC      (`GOC_TIMER_US * `GOC_CLK_MHZ)
`define GOC_TMR_W          13
`define GOC_NFET           6
`define GOC_NPH            3
`define GOC_MODE_LIMIT     2'h0
`define GOC_MODE_LATCH     2'h1
`define GOC_MODE_REPORT    2'h2
`define GOC_MODE_OFF       2'h3
`endif

// ===== goc_pkg.sv
// Purpose: Types for the gate overcurrent protection block
// Assumes: goc_map.svh holds the numbers
// Notes:   None
package goc_pkg;
  typedef enum logic [1:0] {
    GOC_LIMIT,
    GOC_LATCH,
    GOC_REPORT,
    GOC_OFF
  } goc_mode_t;
endpackage

// ===== goc_protect.sv
// Purpose: Overcurrent mode controller for six external transistors
// Assumes: Comparator and PWM pins asynchronous; index 2p = high side, 2p+1 = low side
// Notes:   Quick enable reset arrives already qualified as a pulse input
`timescale 1ns/10ps
`include "goc_map.svh"
module goc_protect (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [1:0]            overcurrent_behaviour_select_i,
  input  wire logic                  per_cycle_limiting_i,
  input  wire logic                  gate_reset_cmd_i,
  input  wire logic                  quick_enable_reset_i,
  input  wire logic [5:0]            pwm_i,
  input  wire logic [5:0]            vds_trip_i,
  output logic      [5:0]            gate_allow_o,
  output logic      [5:0]            oc_status_o,
  output logic                       fault_status_o,
  output logic                       warning_out_n_o,
  output logic                       shutdown_fault_out_n_o,
  output goc_pkg::goc_mode_t         mode_o
);
  import goc_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [5:0] pwm_s;
  logic [5:0] pwm_rise;
  logic [5:0] trip_s;

  genvar g;
  generate
    for (g = 0; g < `GOC_NFET; g = g + 1) begin : g_sync
      goc_sync u_pwm (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (pwm_i[g]),
        .lvl_o     (pwm_s[g]),
        .rise_o    (pwm_rise[g])
      );
      goc_sync u_trip (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (vds_trip_i[g]),
        .lvl_o     (trip_s[g]),
        .rise_o    ()
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Mode decode and trip qualification
  // ------------------------------------------------------------
  goc_mode_t mode;
  logic      clr;
  logic [5:0] off_r;
  logic [5:0] trip;
  logic [5:0] trip_pair;
  logic [5:0] cut;
  logic [5:0] new_trip;
  logic       any_trip;
  logic       second_trip;
  logic       warn_r;
  logic       both_cycled;
  logic [5:0] warn_fets_r;
  logic [5:0] cycled_r;
  logic [`GOC_TMR_W-1:0] tmr_r;
  logic       tmr_done;

  always_comb begin
    unique case (overcurrent_behaviour_select_i)
      `GOC_MODE_LIMIT:  mode = GOC_LIMIT;
      `GOC_MODE_LATCH:  mode = GOC_LATCH;
      `GOC_MODE_REPORT: mode = GOC_REPORT;
      `GOC_MODE_OFF:    mode = GOC_OFF;
    endcase
  end

  assign clr         = gate_reset_cmd_i | quick_enable_reset_i;
  // Only a transistor driven on and not already blanked can trip
  assign trip        = (mode == GOC_OFF) ? 6'h00 : (trip_s & pwm_s & ~off_r);
  assign new_trip    = trip & ~warn_fets_r;
  assign any_trip    = |trip;
  assign second_trip = warn_r & |new_trip;
  // A rise in this very cycle counts, so one PWM cycle per transistor is enough
  assign both_cycled = (((cycled_r | pwm_rise) & warn_fets_r) == warn_fets_r);
  assign tmr_done    = (tmr_r == `GOC_TMR_W'(1));
  // Partner leg of each half-bridge: 2p and 2p+1 swap
  assign trip_pair   = {trip[4], trip[5], trip[2], trip[3], trip[0], trip[1]};
  // Same-cycle cut, so the blanking flop leaves no one-cycle gap
  assign cut         = (mode == GOC_LIMIT) ? trip :
                       (mode == GOC_LATCH) ? (trip | trip_pair) : 6'h00;

  // ------------------------------------------------------------
  // 64 us timer, shared by warning and off-time
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clr) begin
      tmr_r <= '0;
    end else if ((!warn_r && any_trip) || second_trip) begin
      tmr_r <= `GOC_TMR_W'(`GOC_TIMER_CYC);
    end else if (tmr_r != '0) begin
      tmr_r <= tmr_r - `GOC_TMR_W'(1);
    end
  end

  // ------------------------------------------------------------
  // Warning pin tracking
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clr) begin
      warn_r      <= 1'b0;
      warn_fets_r <= '0;
      cycled_r    <= '0;
    end else if (warn_r && tmr_done && !second_trip) begin
      // Expiry goes first, so a comparator held high cannot pin the warning
      warn_r      <= 1'b0;
      warn_fets_r <= '0;
    end else if (any_trip && (mode == GOC_LIMIT || mode == GOC_REPORT)) begin
      // Only a trip on a transistor not yet in the warning wins over an ending window
      warn_r      <= 1'b1;
      warn_fets_r <= warn_r ? (warn_fets_r | trip) : trip;
      cycled_r    <= warn_r ? (cycled_r & ~trip) : '0;
    end else if (warn_r) begin
      cycled_r <= cycled_r | pwm_rise;
      // Report mode has no PWM early end, full pulse only
      if ((mode == GOC_LIMIT && both_cycled && |(pwm_rise & warn_fets_r)) ||
          (mode != GOC_LIMIT && mode != GOC_REPORT)) begin
        warn_r      <= 1'b0;
        warn_fets_r <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // Per-transistor blanking (limit and latch modes)
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || clr) begin
      off_r <= '0;
    end else begin
      for (int i = 0; i < `GOC_NFET; i++) begin
        if (mode == GOC_LATCH) begin
          if (trip[i] || trip[i ^ 1]) begin
            off_r[i] <= 1'b1;
          end
        end else if (mode == GOC_LIMIT) begin
          if (trip[i]) begin
            off_r[i] <= 1'b1;
          end else if (pwm_rise[i]) begin
            off_r[i] <= 1'b0;
          end else if (!per_cycle_limiting_i && tmr_done) begin
            off_r[i] <= 1'b0;
          end
        end else begin
          off_r[i] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Status bits and fault status bit
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      oc_status_o    <= '0;
      fault_status_o <= 1'b0;
    end else begin
      // Trip in the clear cycle still sets
      oc_status_o    <= (clr ? 6'h00 : oc_status_o) | trip;
      fault_status_o <= (clr ? 1'b0 : fault_status_o) |
                        ((mode == GOC_LATCH) & any_trip);
    end
  end

  // ------------------------------------------------------------
  // Output pins, one flop each
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shutdown_fault_out_n_o <= 1'b1;
    end else begin
      // Pin falls with the trip, not a cycle after the sticky bit
      shutdown_fault_out_n_o <= ~((fault_status_o & ~clr) |
                                  ((mode == GOC_LATCH) & any_trip));
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      warning_out_n_o <= 1'b1;
    end else begin
      warning_out_n_o <= ~warn_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gate_allow_o <= '0;
    end else begin
      gate_allow_o <= ~off_r & ~cut;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_o <= GOC_LIMIT;
    end else begin
      mode_o <= mode;
    end
  end
endmodule // goc_protect

// ===== goc_protect_props.sv
// Purpose: Port assertions for the overcurrent block
// Assumes: 100 MHz clock, warning timer 6400 cycles
// Notes:   Warning lengths allow a few cycles of sync slack
`timescale 1ns/10ps
module goc_protect_props import goc_pkg::*; (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       gate_reset_cmd_i,
  input wire logic       quick_enable_reset_i,
  input wire logic [5:0] vds_trip_i,
  input wire logic [5:0] gate_allow_o,
  input wire logic [5:0] oc_status_o,
  input wire logic       fault_status_o,
  input wire logic       warning_out_n_o,
  input wire logic       shutdown_fault_out_n_o,
  input wire goc_mode_t  mode_o
);
  logic        clr;
  logic        new_trip;
  logic [5:0]  st_r;
  logic [5:0]  hb_r;
  logic [13:0] wcnt_r;
  assign clr      = gate_reset_cmd_i | quick_enable_reset_i;
  assign new_trip = |(oc_status_o & ~st_r);
  // Count restarts on each new trip, so retriggers stay bounded
  always_ff @(posedge sys_clk_i) begin
    st_r   <= oc_status_o;
    hb_r   <= {{2{|oc_status_o[5:4]}}, {2{|oc_status_o[3:2]}}, {2{|oc_status_o[1:0]}}};
    wcnt_r <= (new_trip || warning_out_n_o) ? 14'h0 : wcnt_r + 14'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_STATUS_STICKY:
  assert property (!clr && !$past(clr) |=> (oc_status_o | ~$past(oc_status_o)) == 6'h3f)
    else $error("status bit dropped");
  AST_FAULT_PIN:
  assert property ($rose(fault_status_o) |=> !shutdown_fault_out_n_o) else $error("fault pin");
  AST_HALF_BRIDGE:
  assert property (fault_status_o && $past(fault_status_o) |-> (gate_allow_o & hb_r) == 6'h0)
    else $error("half-bridge left on");
  AST_WARN_ON_TRIP:
  assert property (new_trip && mode_o inside {GOC_LIMIT, GOC_REPORT} |=> !warning_out_n_o)
    else $error("no warning");
  AST_REPORT_LEN:
  assert property ($rose(warning_out_n_o) && mode_o == GOC_REPORT |->
    wcnt_r inside {[14'd6396:14'd6404]}) else $error("report pulse length");
  AST_WARN_BOUND:
  assert property (!warning_out_n_o && mode_o != GOC_LATCH |-> wcnt_r <= 14'd6404)
    else $error("warning too long");
  AST_OFF_SILENT:
  assert property (mode_o == GOC_OFF && $past(mode_o, 4) == GOC_OFF |-> !new_trip)
    else $error("trip seen while disabled");
  AST_CLEAR:
  assert property (clr && ($past(vds_trip_i, 3) | $past(vds_trip_i, 2) | $past(vds_trip_i)
    | vds_trip_i) == 6'h0 |-> ##[1:2] (oc_status_o == 6'h0 && !fault_status_o))
    else $error("clear ignored");
endmodule // goc_protect_props
bind goc_protect goc_protect_props goc_protect_props_i (.*);

// ===== goc_sync.sv
// Purpose: Two-flop synchroniser plus rising-edge pulse for one pin
// Assumes: Single clock
// Notes:   First flop read only by second
`timescale 1ns/10ps
module goc_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      lvl_o,
  output logic      rise_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign lvl_o  = sync_r;
  assign rise_o = sync_r & ~prev_r;
endmodule // goc_sync

// ===== testbench.sv
// Purpose: Self-checking bench for goc_protect
// Assumes: Timer not shortened, 6400 cycles
// Notes:   Five passes, limit mode twice (per-cycle limiting on, then off), transistor picked at random
`timescale 1ns/10ps
module testbench;
  import goc_pkg::*;
  logic        clk = 0, rst = 1, cbc = 1, grst = 0, qreq = 0, run = 0, qrst, fst, wn, fn;
  logic [1:0]  md = 2'h0;
  logic [5:0]  hold = 6'h3f, trip = 6'h0, pwm, allow, st;
  logic [16:0] lf = 17'h10a5a;
  goc_mode_t   mo;
  int          error_cnt = 0, num_checks = 0, k, ix, jx;
  goc_host goc_host_i (.sys_clk_i(clk), .run_i(run), .hold_i(hold), .quick_req_i(qreq),
    .pwm_o(pwm), .quick_rst_o(qrst));
  goc_protect goc_protect_i (.sys_clk_i(clk), .rst_i(rst), .overcurrent_behaviour_select_i(md),
    .per_cycle_limiting_i(cbc), .gate_reset_cmd_i(grst), .quick_enable_reset_i(qrst),
    .pwm_i(pwm), .vds_trip_i(trip), .gate_allow_o(allow), .oc_status_o(st),
    .fault_status_o(fst), .warning_out_n_o(wn), .shutdown_fault_out_n_o(fn), .mode_o(mo));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk6({5'h0, got}, {5'h0, exp});
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Gates allowed in pass k, stage s: trip, timer over, PWM cycled
  function automatic logic [5:0] ok_gates(input int k, input int i, input int s);
    if (k == 2) return ~(6'h3 << (i & 6));
    if ((k == 0 && s < 2) || (k == 1 && s == 0)) return ~(6'h1 << i);
    return 6'h3f;
  endfunction
  initial forever #5 clk = ~clk;
  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end
  initial begin
    cyc(3);
    rst = 0;
    chk6(st, 6'h0);
    chk1(fn & wn & (mo === GOC_LIMIT), 1'b1);
    for (k = 0; k < 5; k++) begin
      lf = {lf[15:0], lf[16] ^ lf[13]};
      ix = lf % 6;
      md = (k < 2) ? 2'h0 : 2'(k - 1);
      cbc = (k != 1);
      hold = ~(6'h1 << ix);
      trip = 6'h1 << ix;
      cyc(8);
      chk6(st, 6'h0);
      hold = 6'h3f;
      cyc(6);
      chk6(st, (k == 4) ? 6'h0 : 6'h1 << ix);
      chk1(fn, k != 2);
      if (k != 2) chk1(wn, k == 4);
      chk6(allow, ok_gates(k, ix, 0));
      trip = 6'h0;
      cyc(6500);
      if (k != 2) chk1(wn, 1'b1);
      chk6(allow, ok_gates(k, ix, 1));
      run = 1;
      cyc(48);
      run = 0;
      cyc(6);
      chk6(allow, ok_gates(k, ix, 2));
      chk1(fst, k == 2);
      grst = k[0];
      qreq = !k[0];
      cyc(1);
      grst = 0;
      qreq = 0;
      cyc(6);
      chk6(st, 6'h0);
      chk6(allow, 6'h3f);
      chk1(fn, 1'b1);
    end
    // Off-time: second trip restarts timer, then each PWM cycled by hand
    md = 2'h0;
    cbc = 1'b0;
    jx = (ix + 2) % 6;
    trip = 6'h1 << ix;
    cyc(3000);
    trip = 6'h1 << jx;
    cyc(3500);
    chk6(st, (6'h1 << ix) | (6'h1 << jx));
    chk6(allow, ~((6'h1 << ix) | (6'h1 << jx)));
    chk1(wn, 1'b0);
    trip = 6'h0;
    hold = ~(6'h1 << ix);
    cyc(4);
    hold = 6'h3f;
    cyc(6);
    chk6(allow, ~(6'h1 << jx));
    chk1(wn, 1'b0);
    hold = ~(6'h1 << jx);
    cyc(4);
    hold = 6'h3f;
    cyc(6);
    chk6(allow, 6'h3f);
    chk1(wn, 1'b1);
    finish_test();
  end
endmodule // testbench
